/* hw/cpr_cfg.svh */
/*
  Offsets, field positions, reset values and constants of the CPU
  register block. Assumes inclusion by bare name from the design files.
*/
`ifndef CPR_CFG_SVH
`define CPR_CFG_SVH
// ----------------------------------------
// Register port offsets
// ----------------------------------------
`define CPR_A_GW     6'h00
`define CPR_A_GB     6'h08
`define CPR_A_SW     6'h10
`define CPR_A_PC     6'h11
`define CPR_A_CP     6'h12
`define CPR_A_DP     6'h13
`define CPR_A_EP     6'h14
`define CPR_A_TP     6'h15
`define CPR_A_BR     6'h16
`define CPR_A_STAT   6'h17
`define CPR_A_LW     6'h18
`define CPR_A_BCD    6'h20
`define CPR_A_BIT    6'h28
`define CPR_A_PUSH   6'h30
`define CPR_A_POP    6'h31
`define CPR_A_POPD   6'h32
`define CPR_A_EXC    6'h33
// ----------------------------------------
// Status word layout and reset
// ----------------------------------------
`define CPR_SW_WMASK 16'h870f
`define CPR_SW_RST   16'h0700
// ----------------------------------------
// Vectors, stack and decode constants
// ----------------------------------------
`define CPR_VEC_CP   16'h0000
`define CPR_VEC_PC   16'h0002
`define CPR_STK_STEP 16'h0002
`define CPR_PREFIX   8'h00
`define CPR_SYNC_CNT 2'h3
`endif

/* hw/cpr_pkg.sv */
/*
  Types of the CPU register block. Assumes the cfg header for numbers.
*/
package cpr_pkg;
  typedef enum logic [2:0] {SZ_BIT, SZ_BCD, SZ_BYTE, SZ_WORD, SZ_LONG} cpr_size_e;
  typedef enum logic [2:0] {ST_SYNC, ST_VCP, ST_VPC, ST_RUN, ST_STK, ST_POP} cpr_state_e;
  typedef enum logic [2:0] {DC_EA, DC_EXT, DC_OPC, DC_SOP, DC_SEA} cpr_dec_e;
  typedef struct packed {
    logic       trace;
    logic [3:0] rsv_hi;
    logic [2:0] imask;
    logic [3:0] rsv_lo;
    logic [3:0] condition_code_byte;
  } cpr_sw_s;
  typedef struct packed {
    logic [23:0] addr;
    logic        we;
    logic [1:0]  be;
    logic [15:0] wdata;
  } cpr_mreq_s;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       op2;
    logic [1:0] ea_len;
  } cpr_ibyte_s;
  typedef struct packed {
    logic        special;
    logic        prefix;
    logic [7:0]  ea;
    logic [15:0] ext;
    logic [15:0] opc;
  } cpr_instr_s;
endpackage

/* hw/cpr_mem_fmt.sv */
/*
  Big-endian lane placement and alignment check for one memory access.
  Assumes a 16-bit bus whose upper lane is the even byte.
*/
`timescale 1ns/1ps
module cpr_mem_fmt (
  input  wire logic [15:0] addr_i,
  input  wire logic        word_i,
  input  wire logic        force_word_i,
  input  wire logic [15:0] data_i,
  output logic             err_o,
  output logic [1:0]       be_o,
  output logic [15:0]      lane_o
);
  logic eff_word;
  // ----------------------------------------
  // Lane placement
  // ----------------------------------------
  // Stack traffic is word wide whatever the operand
  assign eff_word = word_i | force_word_i;
  assign err_o    = eff_word & addr_i[0];
  // Even byte on the upper lane, so bits 15..8 map to address n
  always_comb
  begin
    if (eff_word)
    begin
      be_o   = 2'h3;
      lane_o = data_i;
    end
    else if (addr_i[0])
    begin
      be_o   = 2'h1;
      lane_o = {8'h00, data_i[7:0]};
    end
    else
    begin
      be_o   = 2'h2;
      lane_o = {data_i[7:0], 8'h00};
    end
  end
endmodule

/* hw/cpr_core_regs.sv */
/*
  CPU register file with reset vector load, operand formats, stack
  accesses and instruction byte decoder. Assumes a memory slave on clk_i
  that answers mem_ack_i and a byte fetcher that tags each byte with op2 and ea_len.
*/
// Function
// - Reset loads program counter from vector table
// - Reset sets interrupt mask bits to one
// - Reset clears the trace bit
// - General registers and base register undetermined
// - Only code page loaded, maximum mode only
// - Bit, decimal, byte, word, longword operands
// - Bit 15 most significant, word fills
// - Byte operations keep upper eight bits
// - Decimal digits in bits 7:4, 3:0
// - Longword in even register pair, high first
// - Odd word address raises address error
// - Word big-endian, upper byte at even
// - Word bits 15..8 in even byte
// - Exception stack accesses always word size
// - Stack pointer push/pop always word, step two
// - General format: EA, extension, opcode
// - Extension length zero to two from EA
// - Optional zero prefix before general opcode
// - Special format: opcode first, then EA
// - Reserved status bits read zero, unwritable
`timescale 1ns/1ps
`include "cpr_cfg.svh"
module cpr_core_regs (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 max_mode_i,
  input  wire logic [5:0]           addr_i,
  input  wire logic [31:0]          wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic [31:0]               rdata_o,
  output cpr_pkg::cpr_mreq_s        mem_o,
  output logic                      mem_valid_o,
  input  wire logic                 mem_ack_i,
  input  wire logic [15:0]          mem_rdata_i,
  input  wire cpr_pkg::cpr_ibyte_s  ib_i,
  output logic                      dec_valid_o,
  output cpr_pkg::cpr_instr_s       dec_o
);
  logic [15:0]          gr_ff [0:7];
  logic [15:0]          pc_ff;
  cpr_pkg::cpr_sw_s     sw_ff;
  logic [7:0]           cp_ff, dp_ff, ep_ff, tp_ff, br_ff;
  logic [1:0]           mode_sync_ff;
  logic                 max_ff, boot_done_ff, err_ff;
  logic [1:0]           cnt_ff, idx_ff;
  logic                 exc_ff;
  logic [15:0]          push_ff, popd_ff, item;
  cpr_pkg::cpr_state_e  st_ff;
  cpr_pkg::cpr_size_e   sz;
  logic [2:0]           ri;
  logic [15:0]          sp, sp_dec;
  logic                 issue, fmt_err, push_cmd, pop_cmd, exc_cmd;
  logic [1:0]           fmt_be;
  logic [15:0]          fmt_lane;
  logic [2:0]           ext_info;
  cpr_pkg::cpr_dec_e    dst_ff;
  logic [1:0]           dcnt_ff;
  logic                 op2_ff;
  logic [1:0]           ealen_ff;
  logic                 first_ff;

  // ----------------------------------------
  // Decode of the register port
  // ----------------------------------------
  // Operand size follows the window the address falls in
  always_comb
  begin
    ri = addr_i[2:0];
    case (addr_i[5:3])
      3'h0: sz = cpr_pkg::SZ_WORD;
      3'h1: sz = cpr_pkg::SZ_BYTE;
      3'h3: sz = cpr_pkg::SZ_LONG;
      3'h4: sz = cpr_pkg::SZ_BCD;
      3'h5: sz = cpr_pkg::SZ_BIT;
      default: sz = cpr_pkg::SZ_WORD;
    endcase
  end
  assign sp       = gr_ff[7];
  assign sp_dec   = sp - `CPR_STK_STEP;
  assign push_cmd = wr_i && addr_i == `CPR_A_PUSH && st_ff == cpr_pkg::ST_RUN;
  assign pop_cmd  = wr_i && addr_i == `CPR_A_POP && st_ff == cpr_pkg::ST_RUN;
  assign exc_cmd  = wr_i && addr_i == `CPR_A_EXC && st_ff == cpr_pkg::ST_RUN;
  // Saved item: PC, code page in maximum mode only, status word in that order
  always_comb
  begin
    if (!exc_ff)
      item = push_ff;
    else if (idx_ff == 2'h0)
      item = pc_ff;
    else if (idx_ff == 2'h1)
      item = {8'h00, cp_ff};
    else
      item = sw_ff;
  end
  assign issue = st_ff == cpr_pkg::ST_STK && !mem_valid_o && !sp[0];

  cpr_mem_fmt u_fmt (
    .addr_i       (st_ff == cpr_pkg::ST_STK ? sp_dec : sp),
    .word_i       (1'b0),
    .force_word_i (1'b1),
    .data_i       (item),
    .err_o        (fmt_err),
    .be_o         (fmt_be),
    .lane_o       (fmt_lane)
  );

  // ----------------------------------------
  // Mode strap synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mode_sync_ff <= 2'h0;
    else
      mode_sync_ff <= {mode_sync_ff[0], max_mode_i};
  end

  // ----------------------------------------
  // Sequencer: vector load and stack traffic
  // ----------------------------------------
  // Strap is sampled only after the synchroniser has filled
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_ff        <= cpr_pkg::ST_SYNC;
      cnt_ff       <= 2'h0;
      max_ff       <= 1'b0;
      boot_done_ff <= 1'b0;
      mem_valid_o  <= 1'b0;
      mem_o        <= '0;
      idx_ff       <= 2'h0;
      exc_ff       <= 1'b0;
      push_ff      <= 16'h0000;
      popd_ff      <= 16'h0000;
    end
    else
    begin
      case (st_ff)
        cpr_pkg::ST_SYNC:
        begin
          cnt_ff <= cnt_ff + 2'h1;
          if (cnt_ff == `CPR_SYNC_CNT)
          begin
            max_ff      <= mode_sync_ff[1];
            mem_valid_o <= 1'b1;
            mem_o       <= '{addr: {8'h00, mode_sync_ff[1] ? `CPR_VEC_CP : `CPR_VEC_PC},
                             we: 1'b0, be: 2'h3, wdata: 16'h0000};
            st_ff       <= mode_sync_ff[1] ? cpr_pkg::ST_VCP : cpr_pkg::ST_VPC;
          end
        end
        cpr_pkg::ST_VCP:
          if (mem_ack_i)
          begin
            mem_o.addr <= {8'h00, `CPR_VEC_PC};
            st_ff      <= cpr_pkg::ST_VPC;
          end
        cpr_pkg::ST_VPC:
          if (mem_ack_i)
          begin
            mem_valid_o  <= 1'b0;
            boot_done_ff <= 1'b1;
            st_ff        <= cpr_pkg::ST_RUN;
          end
        cpr_pkg::ST_RUN:
        begin
          if (push_cmd || exc_cmd)
          begin
            push_ff <= wdata_i[15:0];
            exc_ff  <= exc_cmd;
            idx_ff  <= 2'h0;
            st_ff   <= cpr_pkg::ST_STK;
          end
          else if (pop_cmd && !sp[0])
          begin
            mem_valid_o <= 1'b1;
            mem_o       <= '{addr: {tp_ff, sp}, we: 1'b0, be: 2'h3, wdata: 16'h0000};
            st_ff       <= cpr_pkg::ST_POP;
          end
        end
        cpr_pkg::ST_STK:
        begin
          // Odd pointer aborts the whole sequence before any access
          if (!mem_valid_o && sp[0])
            st_ff <= cpr_pkg::ST_RUN;
          else if (issue)
          begin
            mem_valid_o <= 1'b1;
            mem_o       <= '{addr: {tp_ff, sp_dec}, we: 1'b1, be: fmt_be, wdata: fmt_lane};
          end
          else if (mem_ack_i)
          begin
            mem_valid_o <= 1'b0;
            if (exc_ff && idx_ff != 2'h2)
              idx_ff <= (idx_ff == 2'h0 && !max_ff) ? 2'h2 : idx_ff + 2'h1;
            else
              st_ff <= cpr_pkg::ST_RUN;
          end
        end
        cpr_pkg::ST_POP:
          if (mem_ack_i)
          begin
            mem_valid_o <= 1'b0;
            popd_ff     <= mem_rdata_i;
            st_ff       <= cpr_pkg::ST_RUN;
          end
        default: st_ff <= cpr_pkg::ST_SYNC;
      endcase
    end
  end

  // ----------------------------------------
  // Address error flag
  // ----------------------------------------
  // A new error wins over a software clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      err_ff <= 1'b0;
    else if ((st_ff == cpr_pkg::ST_STK && !mem_valid_o && fmt_err)
             || (pop_cmd && sp[0]))
      err_ff <= 1'b1;
    else if (wr_i && addr_i == `CPR_A_STAT && wdata_i[0])
      err_ff <= 1'b0;
  end

  // ----------------------------------------
  // Program counter, status word, code page
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sw_ff <= `CPR_SW_RST;
      pc_ff <= 16'h0000;
      cp_ff <= 8'h00;
    end
    else
    begin
      if (st_ff == cpr_pkg::ST_VPC && mem_ack_i)
        pc_ff <= mem_rdata_i;
      else if (wr_i && addr_i == `CPR_A_PC)
        pc_ff <= wdata_i[15:0];
      if (st_ff == cpr_pkg::ST_VCP && mem_ack_i)
        cp_ff <= mem_rdata_i[7:0];
      else if (wr_i && addr_i == `CPR_A_CP)
        cp_ff <= wdata_i[7:0];
      if (wr_i && addr_i == `CPR_A_SW)
        sw_ff <= wdata_i[15:0] & `CPR_SW_WMASK;
    end
  end

  // ----------------------------------------
  // Registers without reset value
  // ----------------------------------------
  // No reset flops: contents are undefined until software writes
  always_ff @(posedge clk_i)
  begin
    if (wr_i && addr_i == `CPR_A_DP)
      dp_ff <= wdata_i[7:0];
    if (wr_i && addr_i == `CPR_A_EP)
      ep_ff <= wdata_i[7:0];
    if (wr_i && addr_i == `CPR_A_TP)
      tp_ff <= wdata_i[7:0];
    if (wr_i && addr_i == `CPR_A_BR)
      br_ff <= wdata_i[7:0];
  end

  // Operand writes into the general registers
  always_ff @(posedge clk_i)
  begin
    if (wr_i)
      case (sz)
        cpr_pkg::SZ_WORD:
          if (addr_i[5:3] == 3'h0)
            gr_ff[ri] <= wdata_i[15:0];
        cpr_pkg::SZ_BYTE, cpr_pkg::SZ_BCD:
          gr_ff[ri][7:0] <= wdata_i[7:0];
        cpr_pkg::SZ_LONG:
          if (!addr_i[2])
          begin
            gr_ff[{addr_i[1:0], 1'b0}] <= wdata_i[31:16];
            gr_ff[{addr_i[1:0], 1'b1}] <= wdata_i[15:0];
          end
        cpr_pkg::SZ_BIT:
          gr_ff[wdata_i[7:5]][wdata_i[3:0]] <= wdata_i[4];
        default: ;
      endcase
    if (issue)
      gr_ff[7] <= sp_dec;
    else if (st_ff == cpr_pkg::ST_POP && mem_ack_i)
      gr_ff[7] <= sp + `CPR_STK_STEP;
  end

  // ----------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 32'h0000_0000;
    else if (!rd_i)
      rdata_o <= 32'h0000_0000;
    else if (addr_i[5:3] == 3'h0)
      rdata_o <= {16'h0000, gr_ff[ri]};
    else if (addr_i[5:3] == 3'h1 || addr_i[5:3] == 3'h4)
      rdata_o <= {24'h00_0000, gr_ff[ri][7:0]};
    else if (addr_i[5:2] == 4'h6)
      rdata_o <= {gr_ff[{addr_i[1:0], 1'b0}], gr_ff[{addr_i[1:0], 1'b1}]};
    else
      case (addr_i)
        `CPR_A_SW:   rdata_o <= {16'h0000, sw_ff & `CPR_SW_WMASK};
        `CPR_A_PC:   rdata_o <= {16'h0000, pc_ff};
        `CPR_A_CP:   rdata_o <= {24'h00_0000, cp_ff};
        `CPR_A_DP:   rdata_o <= {24'h00_0000, dp_ff};
        `CPR_A_EP:   rdata_o <= {24'h00_0000, ep_ff};
        `CPR_A_TP:   rdata_o <= {24'h00_0000, tp_ff};
        `CPR_A_BR:   rdata_o <= {24'h00_0000, br_ff};
        `CPR_A_STAT: rdata_o <= {28'h000_0000, st_ff == cpr_pkg::ST_RUN,
                                 max_ff, boot_done_ff, err_ff};
        `CPR_A_POPD: rdata_o <= {16'h0000, popd_ff};
        default:     rdata_o <= 32'h0000_0000;
      endcase
  end

  // ----------------------------------------
  // Instruction byte decoder
  // ----------------------------------------
  // {known, length} of the extension named by an EA byte
  always_comb
  begin
    casez (ib_i.data)
      8'b1010????, 8'b1011????, 8'b1100????, 8'b1101????: ext_info = 3'h4;
      8'b1110????, 8'h04, 8'b0000?101:                     ext_info = 3'h5;
      8'b1111????, 8'h0c, 8'b0001?101:                     ext_info = 3'h6;
      default:                                            ext_info = 3'h0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dst_ff      <= cpr_pkg::DC_EA;
      dcnt_ff     <= 2'h0;
      op2_ff      <= 1'b0;
      ealen_ff    <= 2'h0;
      first_ff    <= 1'b0;
      dec_valid_o <= 1'b0;
      dec_o       <= '0;
    end
    else
    begin
      dec_valid_o <= 1'b0;
      if (ib_i.valid)
        case (dst_ff)
          cpr_pkg::DC_EA:
          begin
            dec_o    <= '0;
            dcnt_ff  <= ext_info[1:0];
            first_ff <= 1'b1;
            if (ext_info[2])
            begin
              dec_o.ea <= ib_i.data;
              dst_ff   <= ext_info[1:0] == 2'h0 ? cpr_pkg::DC_OPC : cpr_pkg::DC_EXT;
            end
            else
            begin
              dec_o.special  <= 1'b1;
              dec_o.opc[7:0] <= ib_i.data;
              op2_ff         <= ib_i.op2;
              ealen_ff       <= ib_i.ea_len;
              dcnt_ff        <= ib_i.ea_len;
              if (ib_i.op2)
                dst_ff <= cpr_pkg::DC_SOP;
              else if (ib_i.ea_len != 2'h0)
                dst_ff <= cpr_pkg::DC_SEA;
              else
              begin
                dec_valid_o <= 1'b1;
                dst_ff      <= cpr_pkg::DC_EA;
              end
            end
          end
          cpr_pkg::DC_EXT:
          begin
            dec_o.ext <= {dec_o.ext[7:0], ib_i.data};
            dcnt_ff   <= dcnt_ff - 2'h1;
            if (dcnt_ff == 2'h1)
              dst_ff <= cpr_pkg::DC_OPC;
          end
          cpr_pkg::DC_OPC:
            if (ib_i.data == `CPR_PREFIX && !dec_o.prefix)
              dec_o.prefix <= 1'b1;
            else
            begin
              dec_o.opc   <= {dec_o.prefix ? `CPR_PREFIX : 8'h00, ib_i.data};
              dec_valid_o <= 1'b1;
              dst_ff      <= cpr_pkg::DC_EA;
            end
          cpr_pkg::DC_SOP:
          begin
            dec_o.opc <= {dec_o.opc[7:0], ib_i.data};
            if (ealen_ff != 2'h0)
              dst_ff <= cpr_pkg::DC_SEA;
            else
            begin
              dec_valid_o <= 1'b1;
              dst_ff      <= cpr_pkg::DC_EA;
            end
          end
          cpr_pkg::DC_SEA:
          begin
            first_ff <= 1'b0;
            if (first_ff)
              dec_o.ea <= ib_i.data;
            else
              dec_o.ext <= {dec_o.ext[7:0], ib_i.data};
            dcnt_ff <= dcnt_ff - 2'h1;
            if (dcnt_ff == 2'h1)
            begin
              dec_valid_o <= 1'b1;
              dst_ff      <= cpr_pkg::DC_EA;
            end
          end
          default: dst_ff <= cpr_pkg::DC_EA;
        endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_pc_vec;
    @(posedge clk_i) disable iff (!rst_n_i)
    st_ff == cpr_pkg::ST_VPC && mem_ack_i |=> pc_ff == $past(mem_rdata_i);
  endproperty
  a_pc_vec: assert property (p_pc_vec) else $error("pc not loaded from vector");
  property p_mask_boot;
    @(posedge clk_i) disable iff (!rst_n_i)
    !boot_done_ff |-> sw_ff.imask == 3'h7;
  endproperty
  a_mask_boot: assert property (p_mask_boot) else $error("mask not all ones");
  property p_trace_boot;
    @(posedge clk_i) disable iff (!rst_n_i)
    !boot_done_ff |-> !sw_ff.trace;
  endproperty
  a_trace_boot: assert property (p_trace_boot) else $error("trace set at boot");
  property p_rsv;
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == `CPR_A_SW |=> (rdata_o[15:0] & ~`CPR_SW_WMASK) == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved status bits set");
  property p_byte_keep;
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == `CPR_A_GB && st_ff == cpr_pkg::ST_RUN
      |=> gr_ff[0][15:8] == $past(gr_ff[0][15:8]);
  endproperty
  a_byte_keep: assert property (p_byte_keep) else $error("upper byte changed");
  property p_long_rd;
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_i && addr_i[5:2] == 4'h6
      |=> rdata_o == {$past(gr_ff[{addr_i[1:0], 1'b0}]), $past(gr_ff[{addr_i[1:0], 1'b1}])};
  endproperty
  a_long_rd: assert property (p_long_rd) else $error("longword pair wrong");
  property p_no_odd;
    @(posedge clk_i) disable iff (!rst_n_i)
    mem_valid_o && mem_o.be == 2'h3 |-> !mem_o.addr[0];
  endproperty
  a_no_odd: assert property (p_no_odd) else $error("odd word access issued");
  property p_stk_word;
    @(posedge clk_i) disable iff (!rst_n_i)
    mem_valid_o && (st_ff == cpr_pkg::ST_STK || st_ff == cpr_pkg::ST_POP) |-> mem_o.be == 2'h3;
  endproperty
  a_stk_word: assert property (p_stk_word) else $error("stack access not word");
  property p_push_step;
    @(posedge clk_i) disable iff (!rst_n_i)
    issue |=> gr_ff[7] == $past(gr_ff[7]) - `CPR_STK_STEP ##1 mem_valid_o;
  endproperty
  a_push_step: assert property (p_push_step) else $error("push step not two");
  property p_odd_err;
    @(posedge clk_i) disable iff (!rst_n_i)
    pop_cmd && sp[0] |=> err_ff && !mem_valid_o;
  endproperty
  a_odd_err: assert property (p_odd_err) else $error("odd pop without error");
  c_boot_max: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(boot_done_ff) && max_ff);
  c_exc: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    exc_ff && idx_ff == 2'h2 && mem_ack_i);
  c_err: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(err_ff));
  c_pfx: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    dec_valid_o && dec_o.prefix);
endmodule

/* dv/cpr_mem_model.sv */
/*
  Memory slave for the register block: small word store, answers late.
  Assumes requests stay stable until the acknowledge.
*/
`timescale 1ns/1ps
module cpr_mem_model (
  input  wire logic               clk_i,
  input  wire logic               req_i,
  input  wire cpr_pkg::cpr_mreq_s mem_i,
  input  wire logic [2:0]         lat_i,
  output logic                    ack_o,
  output logic [15:0]             rdata_o
);
  // ----------------------------------------
  // Store, preloaded with the two vectors
  // ----------------------------------------
  logic [15:0] mem_ff [16];
  logic [2:0]  cnt_ff;
  initial
  begin
    mem_ff[0] = 16'h00a5;
    mem_ff[1] = 16'h1234;
    {ack_o, cnt_ff, rdata_o} = '0;
  end
  // Answer lat_i + 1 cycles after the request; data inverts when idle so stale reads show
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o)
    begin
      cnt_ff <= cnt_ff + 3'h1;
      if (cnt_ff == lat_i)
      begin
        ack_o <= 1'b1;
        cnt_ff <= 3'h0;
        if (mem_i.we) mem_ff[mem_i.addr[4:1]] <= mem_i.wdata;
        else rdata_o <= mem_ff[mem_i.addr[4:1]];
      end
    end
  end
endmodule

/* dv/cpr_core_regs_tb_top.sv */
/*
  Self-checking bench for the CPU register block.
  Assumes the memory model as far side and a 125 MHz clock.
*/
`timescale 1ns/1ps
`include "cpr_cfg.svh"
module cpr_core_regs_tb_top;
  logic                clk_i = 0, rst_n_i = 0, max_mode_i = 0, wr_i = 0, rd_i = 0, rd_d = 0;
  logic [5:0]          addr_i = '0;
  logic [31:0]         wdata_i = '0, rdata_o;
  logic [15:0]         d, mem_rdata_i;
  logic [2:0]          lat = '0;
  logic                mem_valid_o, mem_ack_i, dec_valid_o;
  cpr_pkg::cpr_mreq_s  mem_o;
  cpr_pkg::cpr_ibyte_s ib_i = '0;
  cpr_pkg::cpr_instr_s dec_o;
  logic [41:0]         rq[$];
  int                  miscompares = 0, total_checks = 0, cyc = 0, seed = 43079;
  always #4 clk_i = ~clk_i;
  cpr_core_regs i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .max_mode_i(max_mode_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .mem_o(mem_o), .mem_valid_o(mem_valid_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .ib_i(ib_i), .dec_valid_o(dec_valid_o), .dec_o(dec_o));
  cpr_mem_model i_mem (.clk_i(clk_i), .req_i(mem_valid_o), .mem_i(mem_o), .lat_i(lat),
    .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // One bus cycle: write v, or read and note v as the expected answer
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= w;
    rd_i <= !w;
    if (!w) rq.push_back({10'h0, v});
    @(posedge clk_i);
    {wr_i, rd_i} <= 2'b00;
  endtask
  // Four bytes back to back, then a gap so the next start follows the decode
  // EA length l only matters on a special-format first byte
  task automatic feed(input logic [31:0] b, input logic [1:0] l, input cpr_pkg::cpr_instr_s e);
    rq.push_back(e);
    for (int i = 3; i >= 0; i--)
    begin
      @(posedge clk_i);
      ib_i <= '{1'b1, b[8*i +: 8], 1'b0, l};
    end
    @(posedge clk_i);
    ib_i.valid <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic chk(input string n, input logic [41:0] e, input logic [41:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Monitor: oldest note against each read answer or decode; hang guard
  always @(posedge clk_i)
  begin
    rd_d <= rd_i;
    if (rd_d) chk("rdata", rq.pop_front(), {10'h0, rdata_o});
    if (dec_valid_o) chk("decode", rq.pop_front(), dec_o);
    if (mem_ack_i) chk("mem_be", 42'h3, {40'h0, mem_o.be});
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    // Boot in both modes; the second pass resets in mid-run
    for (int m = 0; m < 2; m++)
    begin
      // Let the last read answer land before reset clears it
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b0;
      max_mode_i <= m[0];
      lat <= 3'($random(seed));
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (40) @(posedge clk_i);
      bus(0, `CPR_A_SW, 32'h0700);
      bus(0, `CPR_A_PC, 32'h1234);
      bus(0, `CPR_A_CP, m ? 32'ha5 : 32'h0);
      $display("boot test done mode %0d", m);
    end
    d = 16'($random(seed));
    bus(1, `CPR_A_SW, 32'hffff);
    bus(0, `CPR_A_SW, 32'h870f);
    bus(1, `CPR_A_GW, {16'h0, d});
    bus(1, `CPR_A_GB, 32'h3c);
    bus(1, `CPR_A_BIT, 32'h1f);
    bus(1, `CPR_A_BIT, 32'h02);
    bus(0, `CPR_A_GW, {16'h0, 1'b1, d[14:8], 8'h38});
    bus(1, `CPR_A_GW + 6'h2, {16'h0, d});
    bus(1, `CPR_A_GW + 6'h3, {16'h0, ~d});
    bus(0, `CPR_A_LW + 6'h1, {d, ~d});
    bus(1, `CPR_A_BCD + 6'h2, 32'h97);
    bus(0, `CPR_A_BCD + 6'h2, 32'h97);
    bus(0, `CPR_A_GW + 6'h2, {16'h0, d[15:8], 8'h97});
    $display("format test done");
    bus(1, `CPR_A_TP, 32'h0);
    bus(1, `CPR_A_GW + 6'h7, 32'h10);
    bus(1, `CPR_A_PUSH, {16'h0, d});
    repeat (20) @(posedge clk_i);
    bus(1, `CPR_A_POP, 32'h0);
    repeat (20) @(posedge clk_i);
    bus(0, `CPR_A_POPD, {16'h0, d});
    bus(0, `CPR_A_GW + 6'h7, 32'h10);
    bus(1, `CPR_A_EXC, 32'h0);
    repeat (60) @(posedge clk_i);
    bus(0, `CPR_A_GW + 6'h7, 32'h0a);
    bus(1, `CPR_A_POP, 32'h0);
    repeat (20) @(posedge clk_i);
    bus(0, `CPR_A_POPD, 32'h870f);
    bus(1, `CPR_A_GW + 6'h7, 32'h11);
    bus(1, `CPR_A_PUSH, 32'h0);
    repeat (20) @(posedge clk_i);
    bus(0, `CPR_A_STAT, 32'hf);
    bus(1, `CPR_A_STAT, 32'h1);
    bus(0, `CPR_A_STAT, 32'he);
    bus(1, `CPR_A_POP, 32'h0);
    bus(0, `CPR_A_STAT, 32'hf);
    $display("stack test done");
    feed(32'he01200a1, 2'h0, '{1'b0, 1'b1, 8'he0, 16'h0012, 16'h00a1});
    feed(32'hf01234a1, 2'h0, '{1'b0, 1'b0, 8'hf0, 16'h1234, 16'h00a1});
    feed(32'h01a51234, 2'h3, '{1'b1, 1'b0, 8'ha5, 16'h1234, 16'h0001});
    $display("decode test done");
    give_verdict();
  end
endmodule
